// File: design/sag_addr_gen.sv
// What this block does
// - stack pointer holds next free word, grows up
// - pop predecrements, push post-increments
// - call push clears top bit of pc
// - exception push joins status low byte
// - stack limit needs no reset value
// - stack limit bit zero is forced to zero on every write
// - every stack-pointer address compared with limit
// - push at limit fine, next push traps
// - stack address below floor traps underflow
// - boot ram only from boot code
// - secure ram only from secure code
// - file address field is 13 bits, near
// - file ops default to working register zero
// - move reaches the whole data space
// - three-operand first operand is register direct
// - second operand register, memory or literal
// - file direct address taken from instruction
// - indirect uses base, post-modify after access
// - pre-modify adds signed constant first
// - register offset adds base and offset
// - literal offset adds base and literal
// assumes the execute stage holds a request one cycle and that the
// exception unit takes a one-cycle trap pulse on the same clock
`timescale 1ns/1ps
module sag_addr_gen
    import sag_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input sag_req_t req_i,
    input wire logic stack_limit_register_wr_i,
    input wire logic [15:0] stack_limit_register_data_i,
    input wire logic boot_prot_en_i,
    input wire logic [15:0] boot_ram_lo_i,
    input wire logic [15:0] boot_ram_hi_i,
    input wire logic exec_in_boot_i,
    input wire logic sec_prot_en_i,
    input wire logic [15:0] sec_ram_lo_i,
    input wire logic [15:0] sec_ram_hi_i,
    input wire logic exec_in_secure_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    output sag_rsp_t rsp_o,
    output logic [15:0] stack_limit_o,
    output logic [15:0] stack_ptr_o,
    output logic overflow_trap_o,
    output logic underflow_trap_o
);

    logic [15:0] sp_ff;
    logic [15:0] nxt_sp;
    logic [15:0] stack_limit_register_ff;
    logic [15:0] base_val;
    logic [15:0] off_val;
    logic [15:0] sp_q;
    logic [15:0] ea;
    logic [15:0] nxt_base;
    logic base_upd;
    logic uses_sp;
    logic stack_op;
    logic over_cond;
    logic under_cond;
    logic denied;
    logic rf_we;
    logic [3:0] rf_sel;
    logic [15:0] rf_data;
    logic [15:0] push_word;
    logic over_ff;
    logic under_ff;
    logic mem_access;

    // checks run on the cpu clock and rest while reset is high
    default clocking cb_cpu @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // register file; the stack pointer also lives here for direct reads
    sag_default_working_register_file u_default_working_register (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(rf_we),
        .wr_sel_i(rf_sel),
        .wr_data_i(rf_data),
        .rd_a_sel_i(SP_INDEX),
        .rd_b_sel_i(req_i.offset_sel),
        .rd_a_o(sp_q),
        .rd_b_o()
    );

    // registered reads lag one cycle, so base and offset come from a
    // register copy read combinationally; the file drives the pointer output
    logic [15:0] shadow_ff [NUM_DEFAULT_WORKING_REGISTER];

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < NUM_DEFAULT_WORKING_REGISTER; i++)
            begin
                shadow_ff[i] <= ZERO16;
            end
        end
        else if (rf_we)
        begin
            shadow_ff[rf_sel] <= rf_data;
        end
    end

    assign sp_ff = shadow_ff[SP_INDEX];
    assign base_val = shadow_ff[req_i.base_sel];
    assign off_val = shadow_ff[req_i.offset_sel];

    // stack limit: software-written, bit zero forced low
    always_ff @(posedge clk_i)
    begin
        // no reset branch: contents undefined until written
        if (stack_limit_register_wr_i)
        begin
            stack_limit_register_ff <= {stack_limit_register_data_i[15:1], 1'b0};
        end
    end

    // word pushed for call and exception frames
    always_comb
    begin
        case (req_i.op)
            SAG_OP_CALL_PUSH:
                push_word = {8'h00, 1'b0, req_i.pc_high};
            SAG_OP_EXC_PUSH:
                push_word = {req_i.status_low_byte, 1'b0,
                             req_i.pc_high};
            default: push_word = req_i.push_data;
        endcase
    end

    // effective address per mode and stack operation
    always_comb
    begin
        ea = ZERO16;
        nxt_base = base_val;
        base_upd = 1'b0;
        nxt_sp = sp_ff;
        stack_op = 1'b0;
        case (req_i.op)
            SAG_OP_PUSH, SAG_OP_CALL_PUSH, SAG_OP_EXC_PUSH:
            begin
                ea = sp_ff;
                nxt_sp = add16(sp_ff, WORD_STEP);
                stack_op = 1'b1;
            end
            SAG_OP_POP:
            begin
                nxt_sp = 16'(sp_ff - WORD_STEP);
                ea = nxt_sp;
                stack_op = 1'b1;
            end
            SAG_OP_ACCESS:
            begin
                case (req_i.mode)
                    SAG_AM_FILE_DIRECT:
                        ea = (req_i.cls == SAG_CL_MOVE)
                           ? req_i.full_addr
                           : {3'b000, req_i.file_addr};
                    SAG_AM_INDIRECT: ea = base_val;
                    SAG_AM_POST_MOD:
                    begin
                        ea = base_val;
                        nxt_base = req_i.mod_post_down
                            ? 16'(base_val - req_i.modifier)
                            : add16(base_val, req_i.modifier);
                        base_upd = 1'b1;
                    end
                    SAG_AM_PRE_MOD:
                    begin
                        nxt_base = add16(base_val, req_i.modifier);
                        ea = nxt_base;
                        base_upd = 1'b1;
                    end
                    SAG_AM_REG_OFFSET:
                        ea = add16(base_val, off_val);
                    SAG_AM_LIT_OFFSET:
                        ea = add16(base_val, sext_lit(req_i.literal));
                    default: ea = ZERO16; // register direct and literal
                endcase
            end
            default: ea = ZERO16;
        endcase
    end

    // a stack-pointer-based address, from a stack op or indirect mode
    assign uses_sp = stack_op ||
        (req_i.op == SAG_OP_ACCESS && req_i.base_sel == SP_INDEX &&
         req_i.mode inside {SAG_AM_INDIRECT, SAG_AM_POST_MOD,
                            SAG_AM_PRE_MOD, SAG_AM_REG_OFFSET,
                            SAG_AM_LIT_OFFSET});

    // address above limit traps; equal is still allowed
    assign over_cond = req_i.valid && uses_sp &&
                       (ea > stack_limit_register_ff);
    assign under_cond = req_i.valid && uses_sp &&
                        (ea < STACK_FLOOR);

    // every data memory access meets the ram gate, stack frames too,
    // whatever the mode field of a push or pop happens to hold
    assign mem_access = req_i.valid && (stack_op ||
        (req_i.op == SAG_OP_ACCESS && req_i.mode != SAG_AM_REG_DIRECT &&
         req_i.mode != SAG_AM_LITERAL));

    sag_ram_guard u_guard (
        .addr_i(ea),
        .access_i(mem_access),
        .boot_prot_en_i(boot_prot_en_i),
        .boot_ram_lo_i(boot_ram_lo_i),
        .boot_ram_hi_i(boot_ram_hi_i),
        .exec_in_boot_i(exec_in_boot_i),
        .sec_prot_en_i(sec_prot_en_i),
        .sec_ram_lo_i(sec_ram_lo_i),
        .sec_ram_hi_i(sec_ram_hi_i),
        .exec_in_secure_i(exec_in_secure_i),
        .denied_o(denied)
    );

    // register writes: stack pointer, base update or execute write-back;
    // a refused or trapping access leaves the pointers untouched
    always_comb
    begin
        rf_we = 1'b0;
        rf_sel = WREG0_INDEX;
        rf_data = ZERO16;
        if (req_i.valid && !denied && !over_cond && !under_cond)
        begin
            if (stack_op)
            begin
                rf_we = 1'b1;
                rf_sel = SP_INDEX;
                rf_data = nxt_sp;
            end
            else if (base_upd)
            begin
                rf_we = 1'b1;
                rf_sel = req_i.base_sel;
                rf_data = nxt_base;
            end
        end
        if (!rf_we && wr_en_i)
        begin
            rf_we = 1'b1;
            rf_sel = wr_sel_i;
            rf_data = wr_data_i;
        end
    end

    // answer to the execute stage, registered
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rsp_o <= '0;
        end
        else
        begin
            rsp_o.valid <= req_i.valid && req_i.op != SAG_OP_NONE;
            rsp_o.addr <= ea;
            rsp_o.push_word <= push_word;
            rsp_o.is_write <= req_i.op inside {SAG_OP_PUSH, SAG_OP_CALL_PUSH,
                                               SAG_OP_EXC_PUSH};
            rsp_o.use_reg <= req_i.mode inside {SAG_AM_REG_DIRECT,
                                                SAG_AM_LITERAL} ||
                             req_i.cls == SAG_CL_THREE_OP;
            rsp_o.dest_reg <= (req_i.cls == SAG_CL_FILE)
                              ? WREG0_INDEX : req_i.base_sel;
            rsp_o.denied <= denied;
        end
    end

    // one-cycle trap pulses per erroneous access
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            over_ff <= 1'b0;
            under_ff <= 1'b0;
        end
        else
        begin
            over_ff <= over_cond;
            under_ff <= under_cond;
        end
    end

    assign overflow_trap_o = over_ff;
    assign underflow_trap_o = under_ff;
    assign stack_limit_o = stack_limit_register_ff;
    assign stack_ptr_o = sp_q;

    // request shapes that the checks below start from
    sequence s_push_at_limit;
        req_i.valid && stack_op && req_i.op != SAG_OP_POP &&
            sp_ff == stack_limit_register_ff;
    endsequence

    sequence s_clean_push;
        req_i.valid && req_i.op == SAG_OP_PUSH && !over_cond &&
            !under_cond && !denied;
    endsequence

    sequence s_clean_pop;
        req_i.valid && req_i.op == SAG_OP_POP && !over_cond &&
            !under_cond && !denied;
    endsequence

    // a pop from below floor plus one word; a pointer of 0 wraps instead
    sequence s_pop_below_floor;
        req_i.valid && req_i.op == SAG_OP_POP && sp_ff >= WORD_STEP &&
            sp_ff < 16'(STACK_FLOOR + WORD_STEP);
    endsequence

    sequence s_boot_intrusion;
        mem_access && boot_prot_en_i && !exec_in_boot_i &&
            ea >= boot_ram_lo_i && ea <= boot_ram_hi_i;
    endsequence

    sequence s_sec_intrusion;
        mem_access && sec_prot_en_i && !exec_in_secure_i &&
            ea >= sec_ram_lo_i && ea <= sec_ram_hi_i;
    endsequence

    // push at limit must not trap; a trap needs an address above it one cycle before
    a_push_limit: assert property (
        s_push_at_limit |=> !overflow_trap_o)
        else $error("push at limit trapped");
    a_over_pulse: assert property (
        overflow_trap_o |-> $past(ea) > $past(stack_limit_register_ff))
        else $error("overflow trap without cause");
    a_under_floor: assert property (
        s_pop_below_floor |=> underflow_trap_o)
        else $error("underflow trap missed");
    a_push_step: assert property (
        s_clean_push |=> sp_ff == 16'($past(sp_ff) + WORD_STEP))
        else $error("push did not advance pointer");
    a_pop_step: assert property (
        s_clean_pop |=> sp_ff == 16'($past(sp_ff) - WORD_STEP))
        else $error("pop did not lower pointer");
    a_limit_bit0: assert property (
        $past(stack_limit_register_wr_i) |-> stack_limit_register_ff[0] == 1'b0)
        else $error("limit bit zero set");
    a_call_msb: assert property (
        (req_i.valid && req_i.op == SAG_OP_CALL_PUSH) |=>
        rsp_o.push_word[15:7] == 9'h000)
        else $error("call push top bits not clear");
    a_trap_single: assert property (
        overflow_trap_o |-> $past(over_cond))
        else $error("trap not tied to one access");

    // ram gate: any access into a guarded segment from foreign code
    a_guard_boot: assert property (
        s_boot_intrusion |=> rsp_o.denied)
        else $error("boot ram not refused");
    a_guard_sec: assert property (
        s_sec_intrusion |=> rsp_o.denied)
        else $error("secure ram not refused");

endmodule // sag_addr_gen

// File: design/sag_pkg.sv
// package for the stack and address generation block
// assumes one cpu clock, synchronous active-high reset
package sag_pkg;

    localparam int unsigned DW = 16;
    // near data space reached by the file-register address field
    localparam int unsigned FILE_ADDR_W = 13;
    localparam int unsigned NEAR_BYTES = 8192;
    localparam int unsigned LIT5_W = 5;
    localparam int unsigned LIT_W = 10;
    localparam int unsigned STATUS_LOW_W = 8;
    // lowest stack address, protects the special register area
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam int unsigned NUM_DEFAULT_WORKING_REGISTER = 16;
    localparam logic [3:0] SP_INDEX = 4'hf;
    localparam logic [3:0] WREG0_INDEX = 4'h0;
    localparam logic [15:0] STACK_LIMIT_REGISTER_INIT = 16'h0000;

    // fundamental addressing modes
    typedef enum logic [2:0] {
        SAG_AM_FILE_DIRECT = 3'b000,
        SAG_AM_REG_DIRECT = 3'b001,
        SAG_AM_INDIRECT = 3'b010,
        SAG_AM_POST_MOD = 3'b011,
        SAG_AM_PRE_MOD = 3'b100,
        SAG_AM_REG_OFFSET = 3'b101,
        SAG_AM_LIT_OFFSET = 3'b110,
        SAG_AM_LITERAL = 3'b111
    } sag_mode_t;

    // operation class issued by the execute stage
    typedef enum logic [2:0] {
        SAG_OP_NONE = 3'b000,
        SAG_OP_ACCESS = 3'b001,
        SAG_OP_PUSH = 3'b010,
        SAG_OP_POP = 3'b011,
        SAG_OP_CALL_PUSH = 3'b100,
        SAG_OP_EXC_PUSH = 3'b101
    } sag_op_t;

    // instruction class, decides what reach and operands are legal
    typedef enum logic [1:0] {
        SAG_CL_FILE = 2'b00,
        SAG_CL_MOVE = 2'b01,
        SAG_CL_THREE_OP = 2'b10
    } sag_class_t;

    // address request from the execute stage
    typedef struct packed {
        logic valid;
        sag_op_t op;
        sag_class_t cls;
        sag_mode_t mode;
        logic [3:0] base_sel;
        logic [3:0] offset_sel;
        logic [FILE_ADDR_W-1:0] file_addr;
        logic [15:0] full_addr;
        logic [LIT_W-1:0] literal;
        logic [15:0] modifier;
        logic mod_post_down;
        logic [15:0] push_data;
        logic [STATUS_LOW_W-1:0] status_low_byte;
        logic [6:0] pc_high;
    } sag_req_t;

    // address answer to the execute stage
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] push_word;
        logic is_write;
        logic use_reg;
        logic [3:0] dest_reg;
        logic denied;
    } sag_rsp_t;

    // 16-bit sum kept to width
    function automatic logic [15:0] add16(input logic [15:0] a,
                                          input logic [15:0] b);
        add16 = 16'(a + b);
    endfunction

    // sign-extend a literal field to a full word
    function automatic logic [15:0] sext_lit(input logic [LIT_W-1:0] l);
        sext_lit = {{(16-LIT_W){l[LIT_W-1]}}, l};
    endfunction

endpackage

// File: design/sag_default_working_register_file.sv
// working register file with registered read ports
// assumes one cpu clock, one write port, stack pointer at the top index
`timescale 1ns/1ps
module sag_default_working_register_file
    import sag_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_sel_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [3:0] rd_a_sel_i,
    input wire logic [3:0] rd_b_sel_i,
    output logic [15:0] rd_a_o,
    output logic [15:0] rd_b_o
);

    logic [15:0] mem_ff [NUM_DEFAULT_WORKING_REGISTER];

    // write port; cleared on reset so the stack pointer starts defined
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < NUM_DEFAULT_WORKING_REGISTER; i++)
            begin
                mem_ff[i] <= ZERO16;
            end
        end
        else if (wr_en_i)
        begin
            mem_ff[wr_sel_i] <= wr_data_i;
        end
    end

    // registered reads, bypass a write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            rd_a_o <= ZERO16;
            rd_b_o <= ZERO16;
        end
        else
        begin
            rd_a_o <= (wr_en_i && wr_sel_i == rd_a_sel_i) ? wr_data_i
                                                         : mem_ff[rd_a_sel_i];
            rd_b_o <= (wr_en_i && wr_sel_i == rd_b_sel_i) ? wr_data_i
                                                         : mem_ff[rd_b_sel_i];
        end
    end

endmodule // sag_default_working_register_file

// File: design/sag_ram_guard.sv
// boot and secure ram segment gate by executing code segment
// assumes segment bounds and enables are static straps from the core
`timescale 1ns/1ps
module sag_ram_guard
    import sag_pkg::*;
(
    input wire logic [15:0] addr_i,
    input wire logic access_i,
    input wire logic boot_prot_en_i,
    input wire logic [15:0] boot_ram_lo_i,
    input wire logic [15:0] boot_ram_hi_i,
    input wire logic exec_in_boot_i,
    input wire logic sec_prot_en_i,
    input wire logic [15:0] sec_ram_lo_i,
    input wire logic [15:0] sec_ram_hi_i,
    input wire logic exec_in_secure_i,
    output logic denied_o
);

    logic in_boot;
    logic in_sec;

    // boot segment ram only from boot flash code; secure likewise
    always_comb
    begin
        in_boot = (addr_i >= boot_ram_lo_i) && (addr_i <= boot_ram_hi_i);
        in_sec = (addr_i >= sec_ram_lo_i) && (addr_i <= sec_ram_hi_i);
        denied_o = access_i &&
            ((boot_prot_en_i && in_boot && !exec_in_boot_i) ||
             (sec_prot_en_i && in_sec && !exec_in_secure_i));
    end

endmodule // sag_ram_guard

// File: dv/sag_exc_model.sv
// exception unit model: counts stack error trap requests
// assumes one-cycle trap pulses on the shared cpu clock
`timescale 1ns/1ps
module sag_exc_model
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ovf_i,
    input wire logic unf_i,
    output logic [7:0] ovf_cnt_o,
    output logic [7:0] unf_cnt_o
);
    // every cycle a trap stands counts once, so long pulses show up
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ovf_cnt_o <= 8'h00;
            unf_cnt_o <= 8'h00;
        end
        else
        begin
            ovf_cnt_o <= ovf_cnt_o + {7'h00, ovf_i};
            unf_cnt_o <= unf_cnt_o + {7'h00, unf_i};
        end
    end
endmodule // sag_exc_model

// File: dv/sag_addr_gen_tb.sv
// self-checking bench for the address and stack block
// assumes the execute stage is played by the bench tasks
`timescale 1ns/1ps
module sag_addr_gen_tb;
    import sag_pkg::*;
    logic clk_i, sys_rst_i, spw, we, bpe, ebt, spe, esc, ovf, unf;
    logic ovs, uns;
    logic [15:0] spd, wd, lim, sp, sps;
    logic [3:0] ws;
    logic [7:0] oc, uc;
    sag_req_t req_i, rq;
    sag_rsp_t rsp_o, rs;
    int error_cnt, checked, cyc;

    sag_addr_gen i_sag_addr_gen (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req_i), .stack_limit_register_wr_i(spw), .stack_limit_register_data_i(spd),
        .boot_prot_en_i(bpe), .boot_ram_lo_i(16'h2000),
        .boot_ram_hi_i(16'h20FF), .exec_in_boot_i(ebt),
        .sec_prot_en_i(spe), .sec_ram_lo_i(16'h3000),
        .sec_ram_hi_i(16'h30FF), .exec_in_secure_i(esc),
        .wr_en_i(we), .wr_sel_i(ws), .wr_data_i(wd), .rsp_o(rsp_o),
        .stack_limit_o(lim), .stack_ptr_o(sp), .overflow_trap_o(ovf),
        .underflow_trap_o(unf));

    sag_exc_model i_sag_exc_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ovf_i(ovf), .unf_i(unf), .ovf_cnt_o(oc), .unf_cnt_o(uc));

    // free-running cpu clock, 40 ns
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard, run needs about a hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            stop_test;
        end
    end

    task set_reg(input logic [3:0] s, input logic [15:0] d);
        @(negedge clk_i);
        we = 1'b1;
        ws = s;
        wd = d;
        @(negedge clk_i);
        we = 1'b0;
        @(negedge clk_i);
    endtask

    // idle cycle after the write keeps stack reads away from it
    task set_lim(input logic [15:0] d);
        @(negedge clk_i);
        spw = 1'b1;
        spd = d;
        @(negedge clk_i);
        spw = 1'b0;
        @(negedge clk_i);
        check(lim, d & 16'hFFFE);
    endtask

    // one request, snapshot of the answer cycle, then traps must drop
    task send(input sag_op_t op, input sag_mode_t md, input logic [3:0] b);
        @(negedge clk_i);
        rq.valid = 1'b1;
        rq.op = op;
        rq.mode = md;
        rq.base_sel = b;
        req_i = rq;
        @(negedge clk_i);
        req_i = '0;
        rs = rsp_o;
        sps = sp;
        ovs = ovf;
        uns = unf;
        check({15'h0000, rs.valid}, 16'h0001);
        @(negedge clk_i);
        check({14'h0000, ovf, unf}, 16'h0000);
    endtask

    task t_stack;
        set_lim(16'h0903);
        set_reg(SP_INDEX, 16'h0900);
        send(SAG_OP_PUSH, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.addr, 16'h0900);
        check({15'h0000, rs.is_write}, 16'h0001);
        check(sps, 16'h0902);
        send(SAG_OP_PUSH, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.addr, 16'h0902);
        check({15'h0000, ovs}, 16'h0000);
        send(SAG_OP_PUSH, SAG_AM_INDIRECT, SP_INDEX);
        check({15'h0000, ovs}, 16'h0001);
        check(sps, 16'h0904);
        send(SAG_OP_POP, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.addr, 16'h0902);
        check(sps, 16'h0902);
        set_reg(SP_INDEX, 16'h0800);
        send(SAG_OP_POP, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.addr, 16'h07FE);
        check({15'h0000, uns}, 16'h0001);
        check(sps, 16'h0800);
    endtask

    task t_frame;
        set_lim(16'h0FFE);
        set_reg(SP_INDEX, 16'h0A00);
        rq.pc_high = 7'h55;
        rq.status_low_byte = 8'hA5;
        rq.cls = SAG_CL_MOVE;
        send(SAG_OP_CALL_PUSH, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.push_word, 16'h0055);
        send(SAG_OP_EXC_PUSH, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.push_word, 16'hA555);
        check(sps, 16'h0A04);
        set_lim(16'h0A00);
        send(SAG_OP_ACCESS, SAG_AM_INDIRECT, SP_INDEX);
        check(rs.addr, 16'h0A04);
        check({15'h0000, ovs}, 16'h0001);
    endtask

    task t_modes;
        set_reg(4'h3, 16'h1000);
        set_reg(4'h4, 16'h0010);
        rq.cls = SAG_CL_FILE;
        rq.file_addr = 13'h1FFE;
        send(SAG_OP_ACCESS, SAG_AM_FILE_DIRECT, 4'h3);
        check(rs.addr, 16'h1FFE);
        rq.cls = SAG_CL_MOVE;
        rq.full_addr = 16'hC000;
        send(SAG_OP_ACCESS, SAG_AM_FILE_DIRECT, 4'h3);
        check(rs.addr, 16'hC000);
        rq.modifier = 16'h0002;
        rq.mod_post_down = 1'b0;
        send(SAG_OP_ACCESS, SAG_AM_POST_MOD, 4'h3);
        check(rs.addr, 16'h1000);
        send(SAG_OP_ACCESS, SAG_AM_INDIRECT, 4'h3);
        check(rs.addr, 16'h1002);
        rq.modifier = 16'hFFFE;
        send(SAG_OP_ACCESS, SAG_AM_PRE_MOD, 4'h3);
        check(rs.addr, 16'h1000);
        rq.offset_sel = 4'h4;
        send(SAG_OP_ACCESS, SAG_AM_REG_OFFSET, 4'h3);
        check(rs.addr, 16'h1010);
        rq.literal = 10'h3F0;
        send(SAG_OP_ACCESS, SAG_AM_LIT_OFFSET, 4'h3);
        check(rs.addr, 16'h0FF0);
        rq.mod_post_down = 1'b1;
        rq.modifier = 16'h0002;
        send(SAG_OP_ACCESS, SAG_AM_POST_MOD, 4'h3);
        check(rs.addr, 16'h1000);
        send(SAG_OP_ACCESS, SAG_AM_INDIRECT, 4'h3);
        check(rs.addr, 16'h0FFE);
        rq.cls = SAG_CL_THREE_OP;
        send(SAG_OP_ACCESS, SAG_AM_REG_DIRECT, 4'h3);
        check({15'h0000, rs.use_reg}, 16'h0001);
        check({12'h000, rs.dest_reg}, 16'h0003);
        rq.cls = SAG_CL_FILE;
        send(SAG_OP_ACCESS, SAG_AM_LITERAL, 4'h3);
        check({15'h0000, rs.use_reg}, 16'h0001);
        check({12'h000, rs.dest_reg}, {12'h000, WREG0_INDEX});
    endtask

    // s=0 boot segment, s=1 secure segment
    task t_guard(input logic s);
        bpe = ~s;
        spe = s;
        rq.cls = SAG_CL_MOVE;
        ebt = 1'b0;
        esc = 1'b0;
        rq.full_addr = s ? 16'h3010 : 16'h2010;
        send(SAG_OP_ACCESS, SAG_AM_FILE_DIRECT, 4'h0);
        check({15'h0000, rs.denied}, 16'h0001);
        ebt = ~s;
        esc = s;
        send(SAG_OP_ACCESS, SAG_AM_FILE_DIRECT, 4'h0);
        check({15'h0000, rs.denied}, 16'h0000);
    endtask

    // main sequence
    initial
    begin
        sys_rst_i = 1'b1;
        req_i = '0;
        rq = '0;
        {spw, we, bpe, ebt, spe, esc} = 6'h00;
        spd = 16'h0000;
        wd = 16'h0000;
        ws = 4'h0;
        error_cnt = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(negedge clk_i);
        sys_rst_i = 1'b0;
        check(sp, 16'h0000);
        check({15'h0000, rsp_o.valid}, 16'h0000);
        t_stack;
        t_frame;
        t_modes;
        t_guard(1'b0);
        t_guard(1'b1);
        check({8'h00, oc}, 16'h0002);
        check({8'h00, uc}, 16'h0001);
        stop_test;
    end
endmodule // sag_addr_gen_tb
